// ==== rtl/lcdcd_pkg.sv ====
// Package for the LCD command decoder: command field layouts, patterns, mode codes.
// Assumes bytes arrive already framed by a serial slave front end.
package lcdcd_pkg;
	localparam int CONT_BIT = 7;
	localparam logic [1:0] PTR_PAT = 2'h0;
	localparam logic [3:0] SUB_PAT = 4'hc;
	localparam logic [4:0] BANK_PAT = 5'h1e;
	localparam logic [3:0] BLINK_PAT = 4'he;
	localparam logic [1:0] MODE_STATIC = 2'h1;
	localparam logic [1:0] MODE_MUX2 = 2'h2;
	localparam logic [1:0] MODE_MUX3 = 2'h3;
	localparam logic [1:0] MODE_MUX4 = 2'h0;
	localparam logic [4:0] PTR_RST = 5'h00;
	localparam logic [2:0] SUB_RST = 3'h0;
	localparam logic [1:0] RATE_RST = 2'h0;
	localparam int RAM_DEPTH = 32;
	localparam int RAM_WIDTH = 4;
	typedef enum logic {lcdcd_cmd_st, lcdcd_data_st} lcdcd_state_t;
endpackage

// ==== rtl/lcdcd_wr_if.sv ====
// Interface carrying display RAM write requests from the decoder to the RAM.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface lcdcd_wr_if;
	logic we;
	logic [4:0] addr;
	logic [3:0] wdata;
	logic [3:0] wmask;
	logic [4:0] raddr;
	logic [3:0] rdata;
	modport ctrl (output we, addr, wdata, wmask, raddr, input rdata);
	modport ram (input we, addr, wdata, wmask, raddr, output rdata);
endinterface

// ==== rtl/lcdcd_ram.sv ====
// Display RAM of 32 words of 4 bits with per-bit write mask and registered read.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module lcdcd_ram
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Access port.
	lcdcd_wr_if.ram port
);
	logic [lcdcd_pkg::RAM_WIDTH-1:0] mem [lcdcd_pkg::RAM_DEPTH];
	logic [lcdcd_pkg::RAM_WIDTH-1:0] next_word;
	logic [lcdcd_pkg::RAM_WIDTH-1:0] rdata;

	// Merge masked bits into the addressed word.
	always_comb
	begin
		next_word = (mem[port.addr] & ~port.wmask) | (port.wdata & port.wmask);
	end

	// Store writes and register the read word.
	always_ff @(posedge clk)
	begin
		if (port.we)
			mem[port.addr] <= next_word;
		if (!rst_b)
			rdata <= '0;
		else
			rdata <= mem[port.raddr];
	end

	assign port.rdata = rdata;
endmodule

// ==== rtl/lcdcd_top.sv ====
// Command decoder and display controller of a segment LCD driver.
// Assumes bytes are delivered as one-cycle strobes, with a frame start pulse per transfer.
`timescale 1ns/1ps
module lcdcd_top
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Byte stream from the serial front end.
	input wire logic frame_start,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	// Configuration held elsewhere.
	input wire logic [1:0] drive_mode,
	input wire logic [2:0] hw_subaddr,
	// Display read port.
	input wire logic [4:0] disp_raddr,
	output logic [3:0] disp_rdata,
	// Held settings.
	output logic [4:0] data_ptr,
	output logic [2:0] sub_cnt,
	output logic in_bank,
	output logic out_bank,
	output logic alt_bank_blink_sel,
	output logic [1:0] blink_rate_sel,
	output logic alt_blink_active,
	output logic data_phase
);
	lcdcd_wr_if wr ();
	lcdcd_pkg::lcdcd_state_t state;
	lcdcd_pkg::lcdcd_state_t next_state;
	logic [4:0] next_data_ptr;
	logic [2:0] next_sub_cnt;
	logic next_in_bank;
	logic next_out_bank;
	logic next_alt_bank_blink_sel;
	logic [1:0] next_blink_rate_sel;
	logic next_alt_blink_active;
	logic [1:0] fill_idx;
	logic [1:0] next_fill_idx;
	logic we;
	logic next_we;
	logic [4:0] waddr;
	logic [4:0] next_waddr;
	logic [3:0] wdata;
	logic [3:0] next_wdata;
	logic [3:0] wmask;
	logic [3:0] next_wmask;
	logic mux_banked;
	logic is_static;
	logic [1:0] bits_per_addr;
	logic [2:0] rowbits;
	logic selected;

	lcdcd_ram u_ram
	(
		.clk(clk),
		.rst_b(rst_b),
		.port(wr.ram)
	);

	// RAM port wiring; the display reads the addressed RAM word directly, and the output bank is not used.
	assign wr.we = we;
	assign wr.addr = waddr;
	assign wr.wdata = wdata;
	assign wr.wmask = wmask;
	assign wr.raddr = disp_raddr;
	assign disp_rdata = wr.rdata;

	// Mode decoding used by the bank and blink logic.
	always_comb
	begin
		is_static = (drive_mode == lcdcd_pkg::MODE_STATIC);
		mux_banked = is_static || (drive_mode == lcdcd_pkg::MODE_MUX2);
		unique case (drive_mode)
			lcdcd_pkg::MODE_STATIC: rowbits = 3'h1;
			lcdcd_pkg::MODE_MUX2: rowbits = 3'h2;
			lcdcd_pkg::MODE_MUX3: rowbits = 3'h3;
			lcdcd_pkg::MODE_MUX4: rowbits = 3'h4;
		endcase
		bits_per_addr = rowbits[1:0];
		selected = (sub_cnt == hw_subaddr);
	end

	// Command decode, setting updates and display data filling.
	always_comb
	begin
		next_state = state;
		next_data_ptr = data_ptr;
		next_sub_cnt = sub_cnt;
		next_in_bank = in_bank;
		next_out_bank = out_bank;
		next_alt_bank_blink_sel = alt_bank_blink_sel;
		next_blink_rate_sel = blink_rate_sel;
		next_fill_idx = fill_idx;
		next_we = 1'b0;
		next_waddr = waddr;
		next_wdata = wdata;
		next_wmask = wmask;
		if (frame_start)
		begin
			next_state = lcdcd_pkg::lcdcd_cmd_st;
			next_fill_idx = 2'h0;
		end
		else if (byte_valid && state == lcdcd_pkg::lcdcd_cmd_st)
		begin
			if (!byte_data[lcdcd_pkg::CONT_BIT])
				next_state = lcdcd_pkg::lcdcd_data_st;
			// Each defined pattern updates its own setting, the bank pattern only in static and 1:2 modes; others fall through.
			if (byte_data[6:5] == lcdcd_pkg::PTR_PAT)
			begin
				next_data_ptr = byte_data[4:0];
				next_fill_idx = 2'h0;
			end
			else if (byte_data[6:3] == lcdcd_pkg::SUB_PAT)
				next_sub_cnt = byte_data[2:0];
			else if (byte_data[6:2] == lcdcd_pkg::BANK_PAT && mux_banked)
			begin
				next_in_bank = byte_data[1];
				next_out_bank = byte_data[0];
			end
			else if (byte_data[6:3] == lcdcd_pkg::BLINK_PAT)
			begin
				next_alt_bank_blink_sel = byte_data[2];
				next_blink_rate_sel = byte_data[1:0];
			end
			// Mode-set and unmatched bytes change nothing here.
		end
		else if (byte_valid)
		begin
			// A data byte for the selected subaddress fills one bit per row of one RAM word, upper bits if in_bank in banked modes; every data byte moves the pointer on.
			if (selected)
			begin
				next_we = 1'b1;
				next_waddr = data_ptr;
				next_wmask = 4'h0;
				next_wdata = 4'h0;
				for (int i = 0; i < 4; i++)
				begin
					if (2'(i) < bits_per_addr && 2'(i) >= fill_idx)
					begin
						// Offset by two bit positions when the upper input bank is in use.
						next_wmask[(mux_banked && in_bank) ? i + 2 : i] = 1'b1;
						next_wdata[(mux_banked && in_bank) ? i + 2 : i] = 1'b1;
					end
				end
				next_wmask = (rowbits == 3'h4) ? 4'hf : next_wmask;
				next_wdata = byte_data[3:0] & next_wmask;
			end
			next_data_ptr = data_ptr + 5'h1;
			if (data_ptr == 5'h1f)
				next_sub_cnt = sub_cnt + 3'h1;
		end
		// Alternate bank blinking only counts in static and 1:2 modes.
		next_alt_blink_active = next_alt_bank_blink_sel && mux_banked
			&& (next_blink_rate_sel != lcdcd_pkg::RATE_RST);
	end

	// Register all held settings.
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state <= lcdcd_pkg::lcdcd_cmd_st;
			data_ptr <= lcdcd_pkg::PTR_RST;
			sub_cnt <= lcdcd_pkg::SUB_RST;
			in_bank <= 1'b0;
			out_bank <= 1'b0;
			alt_bank_blink_sel <= 1'b0;
			blink_rate_sel <= lcdcd_pkg::RATE_RST;
			alt_blink_active <= 1'b0;
			fill_idx <= 2'h0;
			we <= 1'b0;
			waddr <= lcdcd_pkg::PTR_RST;
			wdata <= 4'h0;
			wmask <= 4'h0;
			data_phase <= 1'b0;
		end
		else
		begin
			state <= next_state;
			data_ptr <= next_data_ptr;
			sub_cnt <= next_sub_cnt;
			in_bank <= next_in_bank;
			out_bank <= next_out_bank;
			alt_bank_blink_sel <= next_alt_bank_blink_sel;
			blink_rate_sel <= next_blink_rate_sel;
			alt_blink_active <= next_alt_blink_active;
			fill_idx <= next_fill_idx;
			we <= next_we;
			waddr <= next_waddr;
			wdata <= next_wdata;
			wmask <= next_wmask;
			data_phase <= (next_state == lcdcd_pkg::lcdcd_data_st);
		end
	end
endmodule

// ==== dv/lcdcd_chk_sva.sv ====
// Checker on the decoder top ports.
// Assumes one clock and the bind below.
`timescale 1ns/1ps
module lcdcd_chk
(
	// Clock, reset and inputs.
	input wire logic clk,
	input wire logic rst_b,
	input wire logic frame_start,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic [1:0] drive_mode,
	// Held settings.
	input wire logic [4:0] data_ptr,
	input wire logic [2:0] sub_cnt,
	input wire logic in_bank,
	input wire logic out_bank,
	input wire logic alt_bank_blink_sel,
	input wire logic [1:0] blink_rate_sel,
	input wire logic alt_blink_active,
	input wire logic data_phase
);
	// Command byte taken, banked mode, and the byte's low bits.
	wire logic ck = byte_valid && !frame_start && !data_phase;
	wire logic bm = drive_mode[1] ^ drive_mode[0];
	wire logic [6:0] b = byte_data[6:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	ptr_load_a: assert property (ck && b[6:5] == 2'h0 |=> data_ptr == $past(b[4:0]))
		else $error("pointer not loaded");
	sub_load_a: assert property (ck && b[6:3] == 4'hc |=> sub_cnt == $past(b[2:0]))
		else $error("subaddress not loaded");
	bank_load_a: assert property (ck && b[6:2] == 5'h1e && bm |=>
		{in_bank, out_bank} == $past(b[1:0])) else $error("bank not loaded");
	bank_ignore_a: assert property (ck && b[6:2] == 5'h1e && !bm |=>
		$stable({in_bank, out_bank})) else $error("bank changed");
	blink_load_a: assert property (ck && b[6:3] == 4'he |=>
		{alt_bank_blink_sel, blink_rate_sel} == $past(b[2:0])) else $error("blink not loaded");
	alt_off_a: assert property (!$past(bm) |-> !alt_blink_active)
		else $error("alternate blink in 1:3 or 1:4");
	phase_set_a: assert property (ck |=> data_phase == !$past(byte_data[7]))
		else $error("phase wrong");
	no_match_a: assert property (ck && (b[6:5] == 2'h2 || b[6:2] == 5'h1f) |=>
		$stable({data_ptr, sub_cnt, in_bank, out_bank, alt_bank_blink_sel, blink_rate_sel}))
		else $error("setting changed");
endmodule
bind lcdcd_top lcdcd_chk lcdcd_chk_i (.clk, .rst_b, .frame_start, .byte_valid, .byte_data,
	.drive_mode, .data_ptr, .sub_cnt, .in_bank, .out_bank, .alt_bank_blink_sel,
	.blink_rate_sel, .alt_blink_active, .data_phase);

// ==== dv/lcdcd_host.sv ====
// Bus master model handing framed bytes to the decoder.
// Assumes the bench calls put from its main sequence.
`timescale 1ns/1ps
module lcdcd_host
(
	// Clock.
	input wire logic clk,
	// Byte stream.
	output logic frame_start,
	output logic byte_valid,
	output logic [7:0] byte_data
);
	// Sends a byte or a frame start for one cycle, then scrambles the data lines.
	task automatic put(input logic [7:0] v, input logic f);
		@(negedge clk);
		frame_start = f;
		byte_valid = !f;
		byte_data = v; // Bit 7 tells whether another command follows.
		@(negedge clk);
		frame_start = 1'b0;
		byte_valid = 1'b0;
		byte_data = ~v;
	endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the decoder against a behavioural model.
// Assumes the host model drives at the falling edge.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic fs, bv, ib, ob, ab, aa, ph, mi, mo, ma, mh;
	logic [7:0] bd;
	logic [1:0] dm = 2'h0;
	logic [2:0] hs = 3'h0;
	logic [4:0] ra = 5'h0;
	logic [3:0] rd;
	logic [4:0] dp, mp;
	logic [2:0] sc, ms;
	logic [1:0] br, mr;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	// Clock and cycle limit.
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			errors = errors + 1;
			close_out();
		end
	end
	lcdcd_host lcdcd_host_i (.clk(clk), .frame_start(fs), .byte_valid(bv), .byte_data(bd));
	lcdcd_top lcdcd_top_i (.clk(clk), .rst_b(rst_b), .frame_start(fs), .byte_valid(bv),
		.byte_data(bd), .drive_mode(dm), .hw_subaddr(hs), .disp_raddr(ra), .disp_rdata(rd),
		.data_ptr(dp), .sub_cnt(sc), .in_bank(ib), .out_bank(ob), .alt_bank_blink_sel(ab),
		.blink_rate_sel(br), .alt_blink_active(aa), .data_phase(ph));
	// Prints the verdict and ends the run.
	task automatic close_out();
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Compares one value with its expectation.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			errors = errors + 1;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	// Compares every held setting with the model.
	task automatic cmp();
		logic ea;
		ea = ma && (dm[1] ^ dm[0]) && mr != 2'h0;
		chk({8'h0, dp, sc}, {8'h0, mp, ms});
		chk({10'h0, ib, ob, ab, br, ph}, {10'h0, mi, mo, ma, mr, mh});
		chk({15'h0, aa}, {15'h0, ea});
	endtask
	// Sends one byte and moves the model on.
	task automatic step(input logic [7:0] v, input logic f);
		lcdcd_host_i.put(v, f);
		if (f)
			mh = 1'b0;
		else if (mh)
		begin
			mp = mp + 5'h1;
			if (mp == 5'h0)
				ms = ms + 3'h1;
		end
		else
		begin
			if (v[6:5] == 2'h0)
				mp = v[4:0];
			if (v[6:3] == 4'hc)
				ms = v[2:0];
			if (v[6:2] == 5'h1e && (dm[1] ^ dm[0]))
				{mi, mo} = v[1:0];
			if (v[6:3] == 4'he)
				{ma, mr} = v[2:0];
			mh = !v[7];
		end
		cmp();
	endtask
	// Holds reset for three cycles and checks the cleared settings.
	task automatic reset();
		@(negedge clk);
		rst_b = 1'b0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		{mp, ms, mi, mo, ma, mr, mh} = 15'h0;
		cmp();
	endtask
	// Main sequence: random traffic, a second reset, then two writes, each read back.
	initial
	begin
		lcdcd_host_i.put(8'h00, 1'b0);
		void'($urandom(95));
		reset();
		repeat (300)
		begin
			dm = 2'($urandom);
			hs = 3'($urandom);
			ra = 5'($urandom);
			step(8'($urandom), ($urandom % 10) == 0);
		end
		dm = 2'h0;
		hs = 3'h0;
		reset();
		step(8'h00, 1'b1);
		step(8'he0, 1'b0);
		step(8'h0a, 1'b0);
		step(8'h05, 1'b0);
		ra = 5'h0a;
		repeat (2) @(negedge clk);
		chk({12'h0, rd}, 16'h0005);
		dm = 2'h1;
		step(8'h00, 1'b1);
		step(8'hfa, 1'b0);
		step(8'h0a, 1'b0);
		step(8'h0b, 1'b0);
		repeat (2) @(negedge clk);
		chk({12'h0, rd}, 16'h0001);
		close_out();
	end
endmodule
